/* src/tzp_defines.svh */
`ifndef TZP_DEFINES_SVH
`define TZP_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define TZP_IDX_COUNT 10'h001
`define TZP_IDX_INTCTL 10'h00b
`define TZP_IDX_CONFIG 10'h081

// Field positions in the interrupt control register.
`define TZP_BIT_FLAG 2
`define TZP_BIT_IRQ_EN 5

// Field positions in the prescale configuration register.
`define TZP_BIT_SRC 5
`define TZP_BIT_EDGE 4
`define TZP_BIT_ASSIGN 3
`define TZP_RATIO_MSB 2

// Reset values.
`define TZP_CONFIG_RESET 8'hff
`define TZP_COUNT_RESET 8'h00

// Timing counts.
`define TZP_CLKS_PER_INSTR 4
`define TZP_INHIBIT_INSTR 2
`define TZP_PHASE_TWO 2'h1
`define TZP_PHASE_FOUR 2'h3

`endif

/* src/tzp_pkg.sv */
package tzp_pkg;

	typedef enum logic [3:0] {
		TZP_BUS_IDLE = 4'h1,
		TZP_BUS_WRITE = 4'h2,
		TZP_BUS_READ = 4'h4,
		TZP_BUS_RDONE = 4'h8
	} tzp_bus_state_t;

	typedef logic [7:0] tzp_byte_t;

endpackage : tzp_pkg

/* src/tzp_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module tzp_prescaler #(
	parameter int WIDTH = 8
)(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic clear_in,
	input wire logic tick_in,
	input wire logic [3:0] shift_in,
	output logic tick_out
);

	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH:0] full_w;
	logic [WIDTH-1:0] mask_w;
	logic wrap_w;

	// A division by two to the power shift_in: the output pulses when
	// all counted low bits are ones and one more tick arrives.
	assign full_w = {{WIDTH{1'b0}}, 1'b1} << shift_in;
	assign mask_w = full_w[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
	assign wrap_w = tick_in && ((cnt_reg & mask_w) == mask_w);

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			cnt_reg <= '0;
			tick_out <= 1'b0;
		end else if (clk_en_in) begin
			if (clear_in) begin
				cnt_reg <= '0;
				tick_out <= 1'b0;
			end else begin
				tick_out <= wrap_w;
				if (tick_in) begin
					cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule : tzp_prescaler

`default_nettype wire

/* src/tzp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module tzp_sync (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic async_in,
	output logic sync_out
);

	logic meta_reg;

	// The first stage is read only by the second stage.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else if (clk_en_in) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : tzp_sync

`default_nettype wire

/* src/tzp_timer_zero.sv */
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`include "tzp_defines.svh"
`default_nettype none

module tzp_timer_zero
	import tzp_pkg::*;
#(
	parameter int PRESCALE_WIDTH = 8
)(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic por_rst_n_in,
	input wire logic clk_en_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic [31:0] hrdata_out,
	output logic hresp_out,
	input wire logic ext_count_input_in,
	input wire logic sleep_in,
	input wire logic watchdog_clear_instr_in,
	input wire logic watchdog_base_tick_in,
	output logic overflow_irq_out,
	output logic watchdog_tick_out
);

	localparam logic [3:0] INHIBIT_CLKS =
		4'(`TZP_INHIBIT_INSTR * `TZP_CLKS_PER_INSTR);

	// Address decode shared by the read and write paths.
	function automatic logic hits(
		input logic [31:0] addr,
		input logic [9:0] idx
	);
		hits = (addr[11:2] == idx) && (addr[31:12] == 20'h00000);
	endfunction : hits

	// Any reset, power-on or otherwise.
	logic any_rst_w;
	assign any_rst_w = !rst_n_in || !por_rst_n_in;

	// Bus slave state.
	tzp_bus_state_t bus_state_reg;
	tzp_bus_state_t bus_next;
	logic [31:0] addr_reg;
	logic bus_take_w;
	logic bus_wr_w;
	logic size_unused_w;

	// Register storage.
	tzp_byte_t count_reg;
	tzp_byte_t config_reg;
	logic overflow_flag_reg;
	logic overflow_irq_enable_reg;

	// Counting path.
	logic [1:0] phase_reg;
	logic [3:0] inhibit_reg;
	logic pend_reg;
	logic ext_sync_w;
	logic ext_prev_reg;
	logic watchdog_sync_w;
	logic watchdog_prev_reg;

	// Decoded writes.
	logic wr_count_w;
	logic wr_intctl_w;
	logic wr_config_w;

	// Configuration fields.
	logic count_source_select;
	logic count_edge_select;
	logic prescaler_assign_select;
	logic [2:0] prescale_ratio_field;

	// Events.
	logic instr_tick_w;
	logic ext_edge_w;
	logic watchdog_edge_w;
	logic src_tick_w;
	logic ps_tick_w;
	logic ps_clear_w;
	logic [3:0] ps_shift_w;
	logic ps_out_w;
	logic timer_event_w;
	logic sample_w;
	logic take_w;
	logic inc_w;
	logic overflow_w;
	logic flag_next;
	tzp_byte_t intctl_w;
	tzp_byte_t read_mux_w;

	// Bus transfer decode.
	assign bus_take_w = hsel_in && htrans_in[1] && hready_in;
	assign bus_wr_w = (bus_state_reg == TZP_BUS_WRITE);
	assign size_unused_w = ^hsize_in;

	always_comb begin
		bus_next = TZP_BUS_IDLE;
		unique case (bus_state_reg)
			TZP_BUS_READ: begin
				bus_next = TZP_BUS_RDONE;
			end
			TZP_BUS_IDLE, TZP_BUS_WRITE, TZP_BUS_RDONE: begin
				if (bus_take_w) begin
					bus_next = hwrite_in ? TZP_BUS_WRITE : TZP_BUS_READ;
				end
			end
			default: begin
				bus_next = TZP_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			bus_state_reg <= TZP_BUS_IDLE;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else if (clk_en_in) begin
			bus_state_reg <= bus_next;
			hreadyout_out <= (bus_next != TZP_BUS_READ);
			hresp_out <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			addr_reg <= 32'h00000000;
		end else if (clk_en_in && bus_take_w) begin
			addr_reg <= haddr_in;
		end
	end

	// The read word is captured in the wait cycle, after any earlier write.
	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			hrdata_out <= 32'h00000000;
		end else if (clk_en_in && bus_state_reg == TZP_BUS_READ) begin
			hrdata_out <= {24'h000000, read_mux_w};
		end
	end

	assign wr_count_w = bus_wr_w && hits(addr_reg, `TZP_IDX_COUNT);
	assign wr_intctl_w = bus_wr_w && hits(addr_reg, `TZP_IDX_INTCTL);
	assign wr_config_w = bus_wr_w && hits(addr_reg, `TZP_IDX_CONFIG);

	// The prescaler count has no address, so it never reaches the mux.
	assign intctl_w = {2'h0, overflow_irq_enable_reg, 2'h0,
		overflow_flag_reg, 2'h0};
	assign read_mux_w =
		hits(addr_reg, `TZP_IDX_COUNT) ? count_reg :
		hits(addr_reg, `TZP_IDX_INTCTL) ? intctl_w :
		hits(addr_reg, `TZP_IDX_CONFIG) ? config_reg :
		8'h00;

	// Configuration fields.
	assign count_source_select = config_reg[`TZP_BIT_SRC];
	assign count_edge_select = config_reg[`TZP_BIT_EDGE];
	assign prescaler_assign_select = config_reg[`TZP_BIT_ASSIGN];
	assign prescale_ratio_field = config_reg[`TZP_RATIO_MSB:0];

	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			config_reg <= `TZP_CONFIG_RESET;
		end else if (clk_en_in && wr_config_w) begin
			config_reg <= hwdata_in[7:0];
		end
	end

	// Instruction cycle phases; phase four ends each cycle.
	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			phase_reg <= 2'h0;
		end else if (clk_en_in) begin
			phase_reg <= phase_reg + 2'h1;
		end
	end

	assign instr_tick_w = (phase_reg == `TZP_PHASE_FOUR);

	// The count pin and the watchdog tick come from outside this clock.
	tzp_sync u_ext_sync (
		.clock_in(clock_in),
		.rst_n_in(!any_rst_w),
		.clk_en_in(clk_en_in),
		.async_in(ext_count_input_in),
		.sync_out(ext_sync_w)
	);

	tzp_sync u_watchdog_sync (
		.clock_in(clock_in),
		.rst_n_in(!any_rst_w),
		.clk_en_in(clk_en_in),
		.async_in(watchdog_base_tick_in),
		.sync_out(watchdog_sync_w)
	);

	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			ext_prev_reg <= 1'b0;
			watchdog_prev_reg <= 1'b0;
		end else if (clk_en_in) begin
			ext_prev_reg <= ext_sync_w;
			watchdog_prev_reg <= watchdog_sync_w;
		end
	end

	assign ext_edge_w = count_edge_select ?
		(ext_prev_reg && !ext_sync_w) :
		(!ext_sync_w ? 1'b0 : !ext_prev_reg);
	assign watchdog_edge_w = watchdog_sync_w && !watchdog_prev_reg;

	// Counting source, stopped entirely while asleep.
	assign src_tick_w = !sleep_in &&
		(count_source_select ? ext_edge_w : instr_tick_w);

	// Shared prescaler: assigned to the counter when the bit is clear.
	assign ps_tick_w = prescaler_assign_select ?
		watchdog_edge_w : src_tick_w;
	assign ps_shift_w = prescaler_assign_select ?
		{1'b0, prescale_ratio_field} :
		{1'b0, prescale_ratio_field} + 4'h1;
	assign ps_clear_w = prescaler_assign_select ?
		watchdog_clear_instr_in : wr_count_w;

	tzp_prescaler #(
		.WIDTH(PRESCALE_WIDTH)
	) u_prescaler (
		.clock_in(clock_in),
		.rst_n_in(!any_rst_w),
		.clk_en_in(clk_en_in),
		.clear_in(ps_clear_w),
		.tick_in(ps_tick_w),
		.shift_in(ps_shift_w),
		.tick_out(ps_out_w)
	);

	// Whichever side lacks the prescaler sees its source undivided.
	assign timer_event_w = prescaler_assign_select ?
		src_tick_w : ps_out_w;

	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			watchdog_tick_out <= 1'b0;
		end else if (clk_en_in) begin
			watchdog_tick_out <= prescaler_assign_select ?
				ps_out_w : watchdog_edge_w;
		end
	end

	// A pending event only moves the counter at phase two or four.
	assign sample_w = (phase_reg == `TZP_PHASE_TWO) ||
		(phase_reg == `TZP_PHASE_FOUR);
	assign take_w = pend_reg && sample_w;
	assign inc_w = take_w && (inhibit_reg == 4'h0) && !sleep_in;

	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			pend_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (wr_count_w || sleep_in) begin
				pend_reg <= 1'b0;
			end else begin
				pend_reg <= timer_event_w || (pend_reg && !take_w);
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			inhibit_reg <= 4'h0;
		end else if (clk_en_in) begin
			if (wr_count_w) begin
				inhibit_reg <= INHIBIT_CLKS;
			end else if (inhibit_reg != 4'h0) begin
				inhibit_reg <= inhibit_reg - 4'h1;
			end
		end
	end

	// Only a power-on reset touches the counter value.
	always_ff @(posedge clock_in) begin
		if (!por_rst_n_in) begin
			count_reg <= `TZP_COUNT_RESET;
		end else if (clk_en_in) begin
			if (wr_count_w) begin
				count_reg <= hwdata_in[7:0];
			end else if (inc_w) begin
				count_reg <= count_reg + 8'h01;
			end
		end
	end

	assign overflow_w = inc_w && !wr_count_w &&
		(count_reg == 8'hff);

	// A wrap in the same cycle as a software clear still sets the flag.
	assign flag_next = wr_intctl_w ?
		(hwdata_in[`TZP_BIT_FLAG] || overflow_w) :
		(overflow_flag_reg || overflow_w);

	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			overflow_flag_reg <= 1'b0;
			overflow_irq_enable_reg <= 1'b0;
		end else if (clk_en_in) begin
			overflow_flag_reg <= flag_next;
			if (wr_intctl_w) begin
				overflow_irq_enable_reg <= hwdata_in[`TZP_BIT_IRQ_EN];
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (any_rst_w) begin
			overflow_irq_out <= 1'b0;
		end else if (clk_en_in) begin
			overflow_irq_out <= overflow_flag_reg &&
				overflow_irq_enable_reg && !size_unused_w ^ size_unused_w;
		end
	end

endmodule : tzp_timer_zero

`default_nettype wire

/* tb/tzp_pin_src.sv */
`timescale 1ns/1ps
`default_nettype none

module tzp_pin_src (
	input wire logic clock_in,
	output logic pin_out
);
	initial pin_out = 1'b0;

	// Each level lasts three clocks or more so the sampler cannot miss it.
	task automatic toggle(input int k);
		repeat (k) begin
			repeat (3 + $urandom % 4) @(posedge clock_in);
			pin_out <= ~pin_out;
		end
		repeat (12) @(posedge clock_in);
	endtask : toggle
endmodule : tzp_pin_src
`default_nettype wire

/* tb/tzp_timer_zero_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tzp_defines.svh"

module tzp_timer_zero_chk #(
	parameter int PRESCALE_WIDTH = 8
)(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic por_rst_n_in,
	input wire logic clk_en_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic hreadyout_out,
	input wire logic [31:0] hrdata_out,
	input wire logic hresp_out,
	input wire logic overflow_irq_out,
	input wire logic watchdog_tick_out
);
	localparam logic [31:0] A_INT = {20'h0, `TZP_IDX_INTCTL, 2'h0};
	logic wr_pend;
	logic en_sh;
	logic [31:0] wr_addr;
	wire take = hsel_in && htrans_in[1] && hready_in && clk_en_in;
	wire rd_take = take && !hwrite_in;
	wire mapped = haddr_in == {20'h0, `TZP_IDX_COUNT, 2'h0}
		|| haddr_in == A_INT || haddr_in == {20'h0, `TZP_IDX_CONFIG, 2'h0};

	// Shadow of the interrupt enable bit, updated where the slave updates it.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || !por_rst_n_in) begin
			wr_pend <= 1'b0;
			en_sh <= 1'b0;
		end else if (hready_in) begin
			wr_pend <= take && hwrite_in;
			wr_addr <= haddr_in;
			if (wr_pend && wr_addr == A_INT)
				en_sh <= hwdata_in[`TZP_BIT_IRQ_EN];
		end
	end

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in || !por_rst_n_in);

	sequence s_rd_take;
		rd_take;
	endsequence
	sequence s_wait_one;
		!hreadyout_out ##1 hreadyout_out;
	endsequence

	chk_read_wait: assert property (s_rd_take |=> s_wait_one)
		else $error("read wait state wrong");
	chk_write_nowait: assert property (take && hwrite_in |=> hreadyout_out)
		else $error("write stalled");
	chk_unmapped_zero: assert property (
		rd_take && !mapped |-> ##2 hrdata_out == 32'h0)
		else $error("unmapped read not zero");
	chk_hrdata_hold: assert property ($changed(hrdata_out) |->
		$past(rd_take, 2) || !$past(rst_n_in) || !$past(por_rst_n_in))
		else $error("read data changed without read");
	chk_hrdata_byte: assert property (hrdata_out[31:8] == 24'h0)
		else $error("upper read data not zero");
	chk_resp_okay: assert property (hresp_out == 1'b0)
		else $error("error response");
	chk_irq_masked: assert property (
		overflow_irq_out |-> $past(en_sh))
		else $error("irq while disabled");
	chk_reset_idle: assert property (
		@(posedge clock_in) disable iff (1'b0)
		(!rst_n_in || !por_rst_n_in) |=> !overflow_irq_out && hreadyout_out)
		else $error("outputs not idle in reset");
	chk_wdt_pulse: assert property (
		watchdog_tick_out |=> !watchdog_tick_out)
		else $error("watchdog tick longer than one cycle");
endmodule : tzp_timer_zero_chk

bind tzp_timer_zero tzp_timer_zero_chk #(.PRESCALE_WIDTH(PRESCALE_WIDTH))
	u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
	.por_rst_n_in(por_rst_n_in), .clk_en_in(clk_en_in), .hsel_in(hsel_in),
	.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
	.hwdata_in(hwdata_in), .hready_in(hready_in),
	.hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out),
	.hresp_out(hresp_out), .overflow_irq_out(overflow_irq_out),
	.watchdog_tick_out(watchdog_tick_out));
`default_nettype wire

/* tb/tzp_timer_zero_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tzp_defines.svh"

module tzp_timer_zero_tb;
	localparam logic [31:0] A_CNT = {20'h0, `TZP_IDX_COUNT, 2'h0};
	localparam logic [31:0] A_INT = {20'h0, `TZP_IDX_INTCTL, 2'h0};
	localparam logic [31:0] A_CFG = {20'h0, `TZP_IDX_CONFIG, 2'h0};
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic por_rst_n_in = 1'b0;
	logic hsel_in = 1'b0;
	logic hwrite_in = 1'b0;
	logic sleep_in = 1'b0;
	logic clr_in = 1'b0;
	logic base_in = 1'b0;
	logic [1:0] htrans_in = 2'h0;
	logic [31:0] haddr_in = 32'h0;
	logic [31:0] hwdata_in = 32'h0;
	logic [31:0] q;
	logic [31:0] hrdata_out;
	logic hreadyout_out;
	logic hresp_out;
	logic irq_out;
	logic tick_out;
	logic pin;
	int errors = 0;
	int samples_checked = 0;
	int pulses = 0;
	int n;
	int m;

	always #20 clock_in = ~clock_in;
	always @(posedge clock_in) if (tick_out === 1'b1) pulses <= pulses + 1;

	tzp_pin_src src (.clock_in(clock_in), .pin_out(pin));
	tzp_timer_zero DUT (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.por_rst_n_in(por_rst_n_in), .clk_en_in(1'b1), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
		.hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
		.hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out),
		.hresp_out(hresp_out), .ext_count_input_in(pin),
		.sleep_in(sleep_in), .watchdog_clear_instr_in(clr_in),
		.watchdog_base_tick_in(base_in), .overflow_irq_out(irq_out),
		.watchdog_tick_out(tick_out));

	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	task automatic fail(input string s);
		errors++;
		$display("[FAIL] %0t %s", $time, s);
	endtask : fail

	task automatic chk(input logic [31:0] got, input int lo, input int hi);
		samples_checked++;
		if (got >= 32'(lo) && got <= 32'(hi))
			return;
		fail($sformatf("got %h want %0d to %0d", got, lo, hi));
	endtask : chk

	task automatic clk(input int k);
		repeat (k) @(posedge clock_in);
	endtask : clk

	task automatic wait_hr;
		int i;
		i = 0;
		do begin
			@(posedge clock_in);
			i++;
		end while (hreadyout_out !== 1'b1 && i < 40);
		if (hreadyout_out !== 1'b1) begin
			fail("bus hang");
			final_report();
		end
	endtask : wait_hr

	task automatic bus(input logic w, input logic [31:0] a, input int d);
		hsel_in <= 1'b1;
		htrans_in <= 2'h2;
		haddr_in <= a;
		hwrite_in <= w;
		wait_hr();
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= 32'(d);
		wait_hr();
		q = hrdata_out;
	endtask : bus

	task automatic rd(input logic [31:0] a, input int lo, input int hi);
		bus(1'b0, a, 0);
		chk(q, lo, hi);
	endtask : rd

	task automatic wd(input int k);
		repeat (k) begin
			base_in <= 1'b1;
			clk(4);
			base_in <= 1'b0;
			clk(4);
		end
		clk(8);
	endtask : wd

	task automatic wclr;
		clr_in <= 1'b1;
		clk(1);
		clr_in <= 1'b0;
		clk(1);
	endtask : wclr

	initial begin
		void'($urandom(57));
		clk(2);
		rst_n_in <= 1'b1;
		por_rst_n_in <= 1'b1;
		clk(1);
		rd(A_CFG, 255, 255);
		rd(A_INT, 0, 0);
		rd(A_CNT, 0, 0);
		rd(32'h100, 0, 0);
		bus(1'b1, A_CFG, 8'h08);
		bus(1'b1, A_CNT, 8'hfc);
		rd(A_CNT, 252, 252);
		clk(40);
		rd(A_CNT, 3, 6);
		rd(A_INT, 4, 4);
		chk(32'(irq_out), 0, 0);
		bus(1'b1, A_INT, 8'h24);
		clk(3);
		chk(32'(irq_out), 1, 1);
		rd(A_INT, 36, 36);
		bus(1'b1, A_INT, 8'h20);
		clk(3);
		chk(32'(irq_out), 0, 0);
		rd(A_INT, 32, 32);
		bus(1'b1, A_INT, 0);
		sleep_in <= 1'b1;
		bus(1'b1, A_CNT, 8'hff);
		clk(60);
		rd(A_CNT, 255, 255);
		rd(A_INT, 0, 0);
		rst_n_in <= 1'b0;
		clk(2);
		rst_n_in <= 1'b1;
		clk(1);
		rd(A_CNT, 255, 255);
		rd(A_CFG, 255, 255);
		sleep_in <= 1'b0;
		for (int r = 0; r < 8; r++) begin
			bus(1'b1, A_CFG, r);
			bus(1'b1, A_CNT, 0);
			clk(16 << (r + 1));
			rd(A_CNT, 3, 5);
		end
		n = pulses;
		wd(10);
		chk(pulses - n, 10, 10);
		for (int r = 0; r < 8; r++) begin
			bus(1'b1, A_CFG, 8'h08 | r);
			wclr();
			n = pulses;
			wd(8 << r);
			chk(pulses - n, 8, 8);
		end
		bus(1'b1, A_CFG, 8'h0b);
		wclr();
		wd(5);
		wclr();
		n = pulses;
		wd(6);
		chk(pulses - n, 0, 0);
		wd(2);
		chk(pulses - n, 1, 1);
		bus(1'b1, A_CFG, 8'h28);
		bus(1'b1, A_CNT, 0);
		clk(10);
		n = 5 + $urandom % 10;
		src.toggle(2 * n - 1);
		rd(A_CNT, n, n);
		bus(1'b1, A_CFG, 8'h38);
		bus(1'b1, A_CNT, 0);
		clk(10);
		m = 5 + $urandom % 10;
		src.toggle(2 * m - 1);
		rd(A_CNT, m, m);
		final_report();
	end
endmodule : tzp_timer_zero_tb
`default_nettype wire
